//--- hdl/ssp_pkg.sv
// Shared constants and types for the synchronous SRAM pin controller
package ssp_pkg;
    localparam int ADDR_W = 18;              // 256K locations
    localparam int DATA_W = 16;              // Data lines
    localparam int LANES = 2;                // Byte lanes, one parity line each
    localparam int BYTE_W = 8;               // Data bits per lane
    localparam int LANE_W = BYTE_W + 1;      // Data plus parity per lane
    localparam int WORD_W = LANES * LANE_W;  // Stored word width
    localparam int BURST_W = 2;              // Burst counter width
    localparam int FIFO_DEPTH = 8;           // Write buffer depth
    localparam logic MODE_LINEAR = 1'b0;     // Strap low selects linear order
    localparam logic [BURST_W-1:0] STEP_ZERO = 2'h0;
    localparam logic [BURST_W-1:0] STEP_ONE = 2'h1;

    // One buffered write: location, lanes to update, lane data
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [LANES-1:0] lanes;
        logic [WORD_W-1:0] data;
    } ssp_wr_t;
endpackage : ssp_pkg

//--- hdl/ssp_fifo.sv
// Small synchronous FIFO with valid/ready on both sides
module ssp_fifo #(
    parameter int WIDTH = 38,
    parameter int DEPTH = 8
) (
    input wire logic mclk, // System clock
    input wire logic nrst, // Asynchronous reset, active low
    input wire logic in_valid, // Write side offers a word
    output logic in_ready, // Space available
    input wire logic [WIDTH-1:0] in_data, // Word to store
    output logic out_valid, // Word available
    input wire logic out_ready, // Read side takes the word
    output logic [WIDTH-1:0] out_data // Oldest word
);
    localparam int PW = $clog2(DEPTH);
    localparam logic [PW:0] FULL_CNT = (PW+1)'(DEPTH);
    localparam logic [PW-1:0] PTR_ONE = PW'(1);
    localparam logic [PW:0] CNT_ONE = (PW+1)'(1);

    logic [WIDTH-1:0] store [DEPTH];
    logic [PW-1:0] wr_ptr_r;
    logic [PW-1:0] rd_ptr_r;
    logic [PW:0] count_r;
    logic push;
    logic pop;

    // Honest flags from the occupancy count
    assign in_ready = (count_r != FULL_CNT);
    assign out_valid = (count_r != '0);
    assign out_data = store[rd_ptr_r];
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;

    // Storage array
    always_ff @(posedge mclk)
    begin
        if (push)
        begin
            store[wr_ptr_r] <= in_data;
        end
    end

    // Pointers and occupancy
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r <= '0;
        end
        else
        begin
            if (push)
            begin
                wr_ptr_r <= wr_ptr_r + PTR_ONE;
            end
            if (pop)
            begin
                rd_ptr_r <= rd_ptr_r + PTR_ONE;
            end
            if (push && !pop)
            begin
                count_r <= count_r + CNT_ONE;
            end
            else if (pop && !push)
            begin
                count_r <= count_r - CNT_ONE;
            end
        end
    end
endmodule : ssp_fifo

//--- hdl/ssp_ctrl.sv
// Pipelined synchronous burst SRAM: select, output drive, capture and burst logic
// What this block does
// - Select when low-a low, high high, low-b low
// - Output enable low lets pins drive
// - Float on write data, post-deselect, deselected
// - Clock gate high holds burst, pipeline and read state; buffer drain and sleep sync go on
// - Sleep request keeps contents, low power
// - Capture input data on rising edge
// - Drive read data of sampled address
// - Parity lines follow their byte lane
// - Strap low linear, high interleaved burst
// - Low address bits load two-bit counter
// - Float outputs one edge after deselect
module ssp_ctrl (
    input wire logic mclk, // 20 MHz clock
    input wire logic nrst, // Asynchronous reset, active low
    input wire logic [ssp_pkg::ADDR_W-1:0] addr, // Address
    input wire logic chip_select_low_a, // Select, active low
    input wire logic chip_select_high, // Select, active high
    input wire logic chip_select_low_b, // Select, active low
    input wire logic write_n, // Write enable, active low
    input wire logic burst_advance_load, // High advances, low loads
    input wire logic [ssp_pkg::LANES-1:0] byte_lane_write_n, // Lane write selects
    input wire logic clock_gate_n, // Clock qualifier, active low
    input wire logic out_enable_n, // Asynchronous output enable
    input wire logic sleep_request, // Asynchronous sleep request
    input wire logic burst_mode_strap, // Burst order strap
    input wire logic [ssp_pkg::DATA_W-1:0] dq_in, // Data pins, input
    output logic [ssp_pkg::DATA_W-1:0] dq_out, // Data pins, output
    output logic dq_oe, // Data pins driven
    input wire logic [ssp_pkg::LANES-1:0] parity_lines_in, // Parity pins, input
    output logic [ssp_pkg::LANES-1:0] parity_lines_out, // Parity pins, output
    output logic parity_lines_oe, // Parity pins driven
    output logic write_ready, // Write buffer has room
    output logic asleep // Low-power state active
);
    localparam int AW = ssp_pkg::ADDR_W;
    localparam int CW = ssp_pkg::BURST_W;

    logic sleep_meta_r;
    logic sleep_r;
    logic strap_taken_r;
    logic mode_r;
    logic op_active_r;
    logic op_write_r;
    logic [AW-1:CW] burst_hi_r;
    logic [CW-1:0] burst_base_r;
    logic [CW-1:0] burst_step_r;
    logic [CW-1:0] step_nxt;
    logic [CW-1:0] burst_lo;
    logic s1_valid_r;
    logic s1_write_r;
    logic [AW-1:0] s1_addr_r;
    logic [ssp_pkg::LANES-1:0] s1_lanes_r;
    logic s2_valid_r;
    logic [AW-1:0] s2_addr_r;
    logic [ssp_pkg::LANES-1:0] s2_lanes_r;
    logic drive_r;
    logic [ssp_pkg::WORD_W-1:0] wr_word;
    logic selected;
    logic advance;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic drain;
    ssp_pkg::ssp_wr_t fifo_in;
    ssp_pkg::ssp_wr_t fifo_out;

    // Sleep request crosses in through two flops
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            sleep_meta_r <= 1'b0;
            sleep_r <= 1'b0;
        end
        else
        begin
            sleep_meta_r <= sleep_request;
            sleep_r <= sleep_meta_r;
        end
    end

    // Burst order strap caught once after reset release
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            strap_taken_r <= 1'b0;
            mode_r <= ssp_pkg::MODE_LINEAR;
        end
        else if (!strap_taken_r)
        begin
            strap_taken_r <= 1'b1;
            mode_r <= burst_mode_strap;
        end
    end

    // An edge counts only with clock gate low, awake, and buffer room
    assign advance = !clock_gate_n && !sleep_r && fifo_in_ready;
    assign selected = !chip_select_low_a && chip_select_high && !chip_select_low_b;
    assign step_nxt = burst_step_r + ssp_pkg::STEP_ONE;

    // Next low address bits in the strapped order
    always_comb
    begin
        if (mode_r == ssp_pkg::MODE_LINEAR)
        begin
            burst_lo = burst_base_r + step_nxt;
        end
        else
        begin
            burst_lo = burst_base_r ^ step_nxt;
        end
    end

    // Burst state: load when advance/load is low, step when it is high
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            op_active_r <= 1'b0;
            op_write_r <= 1'b0;
            burst_hi_r <= '0;
            burst_base_r <= ssp_pkg::STEP_ZERO;
            burst_step_r <= ssp_pkg::STEP_ZERO;
        end
        else if (advance)
        begin
            if (!burst_advance_load)
            begin
                op_active_r <= selected;
                op_write_r <= !write_n;
                burst_hi_r <= addr[AW-1:CW];
                burst_base_r <= addr[CW-1:0];
                burst_step_r <= ssp_pkg::STEP_ZERO;
            end
            else
            begin
                burst_step_r <= step_nxt;
            end
        end
    end

    // Address stage: the access issued at this edge
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            s1_valid_r <= 1'b0;
            s1_write_r <= 1'b0;
            s1_addr_r <= '0;
            s1_lanes_r <= '0;
        end
        else if (advance)
        begin
            s1_lanes_r <= ~byte_lane_write_n;
            if (!burst_advance_load)
            begin
                s1_valid_r <= selected;
                s1_write_r <= !write_n;
                s1_addr_r <= addr;
            end
            else
            begin
                s1_valid_r <= op_active_r;
                s1_write_r <= op_write_r;
                s1_addr_r <= {burst_hi_r, burst_lo};
            end
        end
    end

    // Write data stage: the edge after a write's address edge
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            s2_valid_r <= 1'b0;
            s2_addr_r <= '0;
            s2_lanes_r <= '0;
        end
        else if (advance)
        begin
            s2_valid_r <= s1_valid_r && s1_write_r;
            s2_addr_r <= s1_addr_r;
            s2_lanes_r <= s1_lanes_r;
        end
    end

    // Output drive follows a read one edge later, else floats
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            drive_r <= 1'b0;
        end
        else if (advance)
        begin
            drive_r <= s1_valid_r && !s1_write_r;
        end
    end

    // Pins drive only with drive stage set, enable low, and awake
    assign dq_oe = drive_r && !out_enable_n && !sleep_r;
    assign parity_lines_oe = dq_oe;
    assign write_ready = fifo_in_ready;
    assign asleep = sleep_r;

    // Write data captured at the data edge into the buffer
    assign fifo_in.addr = s2_addr_r;
    assign fifo_in.lanes = s2_lanes_r;
    assign fifo_in.data = wr_word;
    assign drain = !sleep_r;

    // Per lane: storage, read register, pin mapping
    for (genvar i = 0; i < ssp_pkg::LANES; i++)
    begin : g_lane
        logic [ssp_pkg::LANE_W-1:0] lane_mem [2**AW];
        logic [ssp_pkg::LANE_W-1:0] rd_lane_r;

        assign wr_word[i*ssp_pkg::LANE_W +: ssp_pkg::LANE_W] =
            {parity_lines_in[i], dq_in[i*ssp_pkg::BYTE_W +: ssp_pkg::BYTE_W]};
        assign dq_out[i*ssp_pkg::BYTE_W +: ssp_pkg::BYTE_W] =
            rd_lane_r[ssp_pkg::BYTE_W-1:0];
        assign parity_lines_out[i] = rd_lane_r[ssp_pkg::BYTE_W];

        // Buffered write updates only its enabled lanes
        always_ff @(posedge mclk)
        begin
            if (fifo_out_valid && drain && fifo_out.lanes[i])
            begin
                lane_mem[fifo_out.addr] <=
                    fifo_out.data[i*ssp_pkg::LANE_W +: ssp_pkg::LANE_W];
            end
        end

        // Read register loads the location sampled one edge before
        always_ff @(posedge mclk or negedge nrst)
        begin
            if (!nrst)
            begin
                rd_lane_r <= '0;
            end
            else if (advance && s1_valid_r && !s1_write_r)
            begin
                rd_lane_r <= lane_mem[s1_addr_r];
            end
        end
    end

    // Write buffer between data capture and the array
    ssp_fifo #(
        .WIDTH($bits(ssp_pkg::ssp_wr_t)),
        .DEPTH(ssp_pkg::FIFO_DEPTH)
    ) u_wr_fifo (
        .mclk(mclk),
        .nrst(nrst),
        .in_valid(advance && s2_valid_r),
        .in_ready(fifo_in_ready),
        .in_data(fifo_in),
        .out_valid(fifo_out_valid),
        .out_ready(drain),
        .out_data(fifo_out)
    );
endmodule : ssp_ctrl

//--- sim/ssp_ctrl_props.sv
// Checker of the pin rules of the SRAM pin controller
module ssp_ctrl_chk (
    input wire logic mclk, // Clock
    input wire logic nrst, // Reset
    input wire logic chip_select_low_a, // Select
    input wire logic chip_select_high, // Select
    input wire logic chip_select_low_b, // Select
    input wire logic write_n, // Write
    input wire logic burst_advance_load, // Step
    input wire logic clock_gate_n, // Gate
    input wire logic out_enable_n, // Enable
    input wire logic sleep_request, // Sleep
    input wire logic [ssp_pkg::DATA_W-1:0] dq_out, // Data
    input wire logic [ssp_pkg::LANES-1:0] parity_lines_out, // Parity
    input wire logic dq_oe, // Drive
    input wire logic parity_lines_oe, // Drive
    input wire logic write_ready, // Room
    input wire logic asleep // Sleeping
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge mclk);
    endclocking
    default disable iff (!nrst);

    // Accepted edge, a load on it, and all three selects active
    wire logic go = !clock_gate_n && !asleep && write_ready;
    wire logic load = go && !burst_advance_load;
    wire logic sel = !chip_select_low_a && chip_select_high && !chip_select_low_b;

    read_drive_a : assert property (
        load && sel && write_n ##1 go |=> dq_oe == (!out_enable_n && !asleep))
        else $error("read data not driven");
    deselect_float_a : assert property (
        load && !sel ##1 go |=> !dq_oe)
        else $error("driving after deselect");
    write_float_a : assert property (
        load && sel && !write_n ##1 go |=> !dq_oe)
        else $error("driving in write data cycle");
    oe_mask_a : assert property (out_enable_n |-> !dq_oe)
        else $error("driving with enable high");
    gate_hold_a : assert property (
        clock_gate_n |=> $stable(dq_out) && $stable(parity_lines_out))
        else $error("outputs moved while gated");
    sleep_enter_a : assert property (sleep_request [*2] |=> asleep)
        else $error("sleep not entered");
    sleep_exit_a : assert property (!sleep_request [*2] |=> !asleep)
        else $error("sleep not left");
    sleep_float_a : assert property (asleep |-> !dq_oe)
        else $error("driving while asleep");
    parity_same_a : assert property (parity_lines_oe == dq_oe)
        else $error("parity drive differs");
endmodule : ssp_ctrl_chk

bind ssp_ctrl ssp_ctrl_chk chk_u (.mclk, .nrst, .chip_select_low_a, .chip_select_high,
    .chip_select_low_b, .write_n, .burst_advance_load, .clock_gate_n, .out_enable_n,
    .sleep_request, .dq_out, .parity_lines_out, .dq_oe, .parity_lines_oe, .write_ready, .asleep);

//--- sim/ssp_host.sv
// Host controller model that drives the SRAM pins
module ssp_host (
    input wire logic mclk, // Clock
    input wire logic go, // Device takes this edge
    output logic [17:0] addr, // Address
    output logic [2:0] cs, // Selects low_a, high, low_b
    output logic write_n, // Write
    output logic burst_advance_load, // Low loads
    output logic [1:0] byte_lane_write_n, // Lane writes
    output logic [17:0] wd_bus // Parity and data lines
);
    timeunit 1ns;
    timeprecision 1ns;
    logic wr_op = 1'b0;
    logic wr_d1 = 1'b0;
    logic [17:0] wd_now, wd_d1;
    wire logic cur_wr = burst_advance_load ? wr_op : (cs == 3'h2 && !write_n);

    // Idle bus: deselect
    initial
    begin
        {addr, cs, write_n, burst_advance_load, byte_lane_write_n, wd_bus} =
            {18'h0, 3'h5, 1'b1, 1'b0, 2'h3, 18'h0};
    end

    // One beat; on a step the ignored selects, write and address are driven wrong
    task automatic beat(input logic load, input logic [2:0] c, input logic w,
        input logic [17:0] a, input logic [1:0] b, input logic [17:0] d);
        @(posedge mclk);
        burst_advance_load <= !load;
        cs <= load ? c : ~c;
        write_n <= load ? !w : w;
        addr <= load ? a : ~a;
        byte_lane_write_n <= b;
        wd_now <= d;
    endtask : beat

    // Write data goes out one edge after the write is taken, else the lines wander
    always @(posedge mclk)
        if (go)
        begin
            wr_op <= cur_wr;
            wr_d1 <= cur_wr;
            wd_d1 <= wd_now;
            wd_bus <= wr_d1 ? wd_d1 : ~wd_bus;
        end
endmodule : ssp_host

//--- sim/ssp_ctrl_tb.sv
// Testbench for the SRAM pin controller
module ssp_ctrl_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic mclk = 1'b0;
    logic nrst = 1'b0;
    logic clock_gate_n = 1'b0;
    logic out_enable_n = 1'b0;
    logic sleep_request = 1'b0;
    logic burst_mode_strap = 1'b0;
    logic [17:0] addr, wd;
    logic [2:0] cs;
    logic write_n, burst_advance_load, dq_oe, parity_lines_oe, write_ready, asleep;
    logic [1:0] byte_lane_write_n, par;
    logic [15:0] dq;
    logic [17:0] ref_mem [logic [17:0]];
    int mismatches = 0;
    int cmp_count = 0;

    ssp_ctrl dut_u (.mclk, .nrst, .addr, .chip_select_low_a(cs[2]), .chip_select_high(cs[1]),
        .chip_select_low_b(cs[0]), .write_n, .burst_advance_load,
        .byte_lane_write_n, .clock_gate_n, .out_enable_n, .sleep_request,
        .burst_mode_strap, .dq_in(wd[15:0]), .dq_out(dq), .dq_oe, .parity_lines_in(wd[17:16]),
        .parity_lines_out(par), .parity_lines_oe, .write_ready, .asleep);
    ssp_host host_u (.mclk, .go(!clock_gate_n && !asleep && write_ready), .addr, .cs,
        .write_n, .burst_advance_load, .byte_lane_write_n, .wd_bus(wd));

    // 20 MHz clock
    initial
    begin
        forever #25 mclk = ~mclk;
    end

    task automatic chk(input logic [18:0] got, input logic [18:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
            mismatches++;
        end
    endtask : chk

    task automatic restart(input logic s);
        @(posedge mclk) nrst <= 1'b0;
        burst_mode_strap <= s;
        repeat (20) @(posedge mclk);
        nrst <= 1'b1;
        repeat (2) @(posedge mclk);
    endtask : restart

    function automatic logic [17:0] baddr(input logic [17:0] a, input int k);
        return {a[17:2], burst_mode_strap ? a[1:0] ^ k[1:0] : a[1:0] + k[1:0]};
    endfunction : baddr

    task automatic desel();
        host_u.beat(1'b1, 3'h5, 1'b0, 18'h0, 2'h3, 18'h0);
    endtask : desel

    // Burst of n beats then three deselects; read data compared as it arrives
    task automatic xfer(input logic w, input logic [17:0] a, input int n, input logic [1:0] b,
        input logic [17:0] d);
        logic [17:0] m;
        m = {~b, {8{~b[1]}}, {8{~b[0]}}};
        for (int k = 0; k < n + 3; k++)
        begin
            if (k < n)
                host_u.beat(k == 0, 3'h2, w, a, b, d + 18'(k));
            else
                desel();
            if (w && k < n)
                ref_mem[baddr(a, k)] = (ref_mem[baddr(a, k)] & ~m) | ((d + 18'(k)) & m);
            #1;
            chk(write_ready, 1'b1);
            if (k >= 2)
                chk({dq_oe, parity_lines_oe}, {2{!w && k < n + 2}});
            if (!w && k >= 2 && k < n + 2)
                chk({par, dq}, ref_mem[baddr(a, k - 2)]);
        end
    endtask : xfer

    task automatic t_linear();
        xfer(1'b1, 18'h00101, 4, 2'h0, 18'h2a5c3);
        xfer(1'b1, 18'h00103, 1, 2'h2, 18'h15a3c);
        xfer(1'b1, 18'h00100, 1, 2'h1, 18'h0f0f0);
        xfer(1'b0, 18'h00102, 4, 2'h3, 18'h0);
    endtask : t_linear

    task automatic t_selects();
        for (int c = 0; c < 8; c++)
        begin
            if (c != 2)
            begin
                host_u.beat(1'b1, 3'(c), 1'b0, 18'h00101, 2'h3, 18'h0);
                repeat (2) desel();
                #1 chk(dq_oe, 1'b0);
            end
        end
    endtask : t_selects

    task automatic t_hold();
        host_u.beat(1'b1, 3'h2, 1'b0, 18'h00101, 2'h3, 18'h0);
        repeat (2) desel();
        clock_gate_n <= 1'b1;
        repeat (3) @(posedge mclk);
        #1 chk({dq_oe, par, dq}, {1'b1, ref_mem[18'h00101]});
        @(posedge mclk) out_enable_n <= 1'b1;
        #1 chk(dq_oe, 1'b0);
        @(posedge mclk) out_enable_n <= 1'b0;
        #1 chk(dq_oe, 1'b1);
        @(posedge mclk) clock_gate_n <= 1'b0;
        repeat (2) desel();
        #1 chk(dq_oe, 1'b0);
    endtask : t_hold

    task automatic t_sleep();
        @(posedge mclk) sleep_request <= 1'b1;
        repeat (3) @(posedge mclk);
        #1 chk({asleep, dq_oe}, 2'h2);
        @(posedge mclk) sleep_request <= 1'b0;
        repeat (3) @(posedge mclk);
        #1 chk(asleep, 1'b0);
        xfer(1'b0, 18'h00100, 4, 2'h3, 18'h0);
    endtask : t_sleep

    // Write buffer seen through the pins: back-to-back writes never stall, data reads back
    task automatic t_fifo();
        xfer(1'b1, 18'h00200, 4, 2'h0, 18'h1e1e1);
        xfer(1'b1, 18'h00203, 2, 2'h1, 18'h0a5a5);
        xfer(1'b0, 18'h00200, 4, 2'h3, 18'h0);
    endtask : t_fifo

    task automatic t_inter();
        xfer(1'b0, 18'h00103, 4, 2'h3, 18'h0);
        xfer(1'b1, 18'h00105, 4, 2'h0, 18'h3c3c1);
        xfer(1'b0, 18'h00106, 4, 2'h3, 18'h0);
    endtask : t_inter

    task automatic conclude();
        $display("mismatches %0d, comparisons %0d", mismatches, cmp_count);
        if (mismatches == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : conclude

    // Main sequence
    initial
    begin
        restart(1'b0);
        t_linear();
        t_selects();
        t_hold();
        t_sleep();
        t_fifo();
        restart(1'b1);
        t_inter();
        conclude();
    end

    // Watchdog: the tests need well under a thousand cycles
    initial
    begin
        #100000;
        mismatches++;
        conclude();
    end
endmodule : ssp_ctrl_tb
